// >>> src/tbt_top.sv
// time base prescaler, its two interrupt flags and timers 0 and 1 behind an Avalon-MM slave
`timescale 1ns/10ps
`include "tbt_defs.svh"

// Summary of operation
// - two-bit enable field gates first and second prescaler interrupts independently.
// - first tap picks stage 11/13/15/17, second tap stage 12/14/16/18.
// - snapshot low byte shows stages 5-12, high byte stages 13-20.
// - request flags read 1 while pending; writing 0 clears, writing 1 never sets.
// - unused bits of the request flag register always read as 1.
// - six run bits, bits 0 and 1 for timers 0 and 1; 0 stops, 1 lets it count.
// - timer 0 source: control-track pulse, pin, stage 6 or stage 10.
// - timer 1 source: its pin, stage 2, stage 4 or stage 6.
// - clear-on-match bit per timer returns the counter to zero on match.
// - writing 1 to a soft-clear bit zeroes that counter at once; bit reads 0.
// - timer 0 location: writes load the compare byte, reads give the count.
// - timer 1 is 16 bits over two bytes; write compare, read count.
// - registers decode inside the 144-location window at the bottom of space.
module tbt_top (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic control_track_pulse,
   input wire logic t0_external_input,
   input wire logic t1_external_input,
   output logic prescaler_irq_first,
   output logic prescaler_irq_second,
   output logic t0_match_irq,
   output logic t1_match_irq
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [`TBT_MODE_W-1:0] mode_reg;
   logic [`TBT_RUN_W-1:0] run_reg;
   tbt_pkg::tbt_byte_t ctrl_reg;
   tbt_pkg::tbt_byte_t t0_cmp_reg;
   tbt_pkg::tbt_byte_t t1_cmp_lo_reg;
   tbt_pkg::tbt_byte_t t1_cmp_hi_reg;
   logic flag_first_reg;
   logic flag_second_reg;
   logic flag_first_next;
   logic flag_second_next;
   logic irq_first_reg;
   logic irq_second_reg;
   logic [2:0] pin_s1_reg;
   logic [2:0] pin_s2_reg;
   logic [2:0] pin_s3_reg;
   logic [2:0] pin_lvl_reg;
   logic [2:0] pin_lvl_next;
   logic [2:0] pin_rise_reg;
   logic [`TBT_PRESC_W-1:0] presc_cnt;
   logic [`TBT_PRESC_W-1:0] presc_tick;

   tbt_tmr_if #(.W(8)) t0_if ();
   tbt_tmr_if #(.W(16)) t1_if ();

   // ----------------------------------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------------------------------
   wire req = avs_read | avs_write;
   wire ack = req & ~wait_reg;
   wire wr_stb = avs_write & ~wait_reg & avs_byteenable[0];
   wire rd_take = avs_read & wait_reg;
   wire tbt_pkg::tbt_byte_t wbyte = avs_writedata[7:0];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wait_reg <= 1'h1;
      end else begin
         wait_reg <= ~(req & wait_reg);
      end
   end

   assign avs_waitrequest = wait_reg;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire in_window = (avs_address <= `TBT_WIN_TOP);
   wire sel_mode = in_window & (avs_address == `TBT_OFS_MODE);
   wire sel_snap_lo = in_window & (avs_address == `TBT_OFS_SNAP_LO);
   wire sel_snap_hi = in_window & (avs_address == `TBT_OFS_SNAP_HI);
   wire sel_flags = in_window & (avs_address == `TBT_OFS_FLAGS);
   wire sel_run = in_window & (avs_address == `TBT_OFS_RUN);
   wire sel_ctrl = in_window & (avs_address == `TBT_OFS_CTRL);
   wire sel_t0 = in_window & (avs_address == `TBT_OFS_T0);
   wire sel_t1_lo = in_window & (avs_address == `TBT_OFS_T1_LO);
   wire sel_t1_hi = in_window & (avs_address == `TBT_OFS_T1_HI);

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   wire tbt_pkg::tbt_byte_t snap_lo = presc_cnt[`TBT_SNAP_LO_LSB +: 8];
   wire tbt_pkg::tbt_byte_t snap_hi = presc_cnt[`TBT_SNAP_HI_LSB +: 8];
   wire tbt_pkg::tbt_byte_t flags_rd = `TBT_FLAGS_ONES | {2'h0, flag_second_reg, flag_first_reg, 4'h0};
   wire tbt_pkg::tbt_byte_t rd_byte =
      sel_mode ? {2'h0, mode_reg} :
      sel_snap_lo ? snap_lo :
      sel_snap_hi ? snap_hi :
      sel_flags ? flags_rd :
      sel_run ? {2'h0, run_reg} :
      sel_ctrl ? ctrl_reg :
      sel_t0 ? t0_if.count :
      sel_t1_lo ? t1_if.count[7:0] :
      sel_t1_hi ? t1_if.count[15:8] :
      8'h00;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_take) begin
         rdata_reg <= {24'h000000, rd_byte};
      end
   end

   assign avs_readdata = rdata_reg;

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   // plain stores are assumed: a write replaces every field at once
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_reg <= `TBT_RST_MODE;
         run_reg <= `TBT_RST_RUN;
         ctrl_reg <= `TBT_RST_CTRL;
      end else if (wr_stb) begin
         if (sel_mode) begin
            mode_reg <= wbyte[`TBT_MODE_W-1:0];
         end
         if (sel_run) begin
            run_reg <= wbyte[`TBT_RUN_W-1:0];
         end
         if (sel_ctrl) begin
            ctrl_reg <= wbyte & `TBT_CTRL_KEEP;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         t0_cmp_reg <= `TBT_RST_CMP;
         t1_cmp_lo_reg <= `TBT_RST_CMP;
         t1_cmp_hi_reg <= `TBT_RST_CMP;
      end else if (wr_stb) begin
         if (sel_t0) begin
            t0_cmp_reg <= wbyte;
         end
         if (sel_t1_lo) begin
            t1_cmp_lo_reg <= wbyte;
         end
         if (sel_t1_hi) begin
            t1_cmp_hi_reg <= wbyte;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers: bit 0 control track, 1 timer 0 pin, 2 timer 1 pin
   // ----------------------------------------------------------------
   wire [2:0] pin_raw = {t1_external_input, t0_external_input, control_track_pulse};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         assign pin_lvl_next[gi] = (pin_s2_reg[gi] == pin_s3_reg[gi]) ? pin_s3_reg[gi] : pin_lvl_reg[gi];
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_s3_reg <= 3'h0;
         pin_lvl_reg <= 3'h0;
         pin_rise_reg <= 3'h0;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_lvl_reg <= pin_lvl_next;
         pin_rise_reg <= pin_lvl_next & ~pin_lvl_reg;
      end
   end

   // ----------------------------------------------------------------
   // prescaler and its interrupt taps
   // ----------------------------------------------------------------
   tbt_prescaler #(.W(`TBT_PRESC_W)) u_presc (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .count(presc_cnt),
      .tick(presc_tick)
   );

   wire [3:0] tap1_set = {presc_tick[`TBT_TAP1_S3], presc_tick[`TBT_TAP1_S2],
                          presc_tick[`TBT_TAP1_S1], presc_tick[`TBT_TAP1_S0]};
   wire [3:0] tap2_set = {presc_tick[`TBT_TAP2_S3], presc_tick[`TBT_TAP2_S2],
                          presc_tick[`TBT_TAP2_S1], presc_tick[`TBT_TAP2_S0]};
   wire tbt_pkg::tbt_sel_t tap1_sel = mode_reg[`TBT_MODE_TAP1_LSB +: 2];
   wire tbt_pkg::tbt_sel_t tap2_sel = mode_reg[`TBT_MODE_TAP2_LSB +: 2];
   wire tap1_tick = tap1_set[tap1_sel];
   wire tap2_tick = tap2_set[tap2_sel];
   wire en_first = mode_reg[`TBT_MODE_EN1_BIT];
   wire en_second = mode_reg[`TBT_MODE_EN2_BIT];
   wire set_first = tap1_tick & en_first;
   wire set_second = tap2_tick & en_second;
   wire clr_first = wr_stb & sel_flags & ~wbyte[`TBT_FLAG_FIRST_BIT];
   wire clr_second = wr_stb & sel_flags & ~wbyte[`TBT_FLAG_SECOND_BIT];

   // a new request in the clearing cycle survives the clear
   assign flag_first_next = set_first | (flag_first_reg & ~clr_first);
   assign flag_second_next = set_second | (flag_second_reg & ~clr_second);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         flag_first_reg <= 1'h0;
         flag_second_reg <= 1'h0;
         irq_first_reg <= 1'h0;
         irq_second_reg <= 1'h0;
      end else begin
         flag_first_reg <= flag_first_next;
         flag_second_reg <= flag_second_next;
         irq_first_reg <= flag_first_next & en_first;
         irq_second_reg <= flag_second_next & en_second;
      end
   end

   assign prescaler_irq_first = irq_first_reg;
   assign prescaler_irq_second = irq_second_reg;

   // ----------------------------------------------------------------
   // timer count sources and controls
   // ----------------------------------------------------------------
   wire [3:0] t0_srcs = {presc_tick[`TBT_T0_TAP_B], presc_tick[`TBT_T0_TAP_A], pin_rise_reg[1], pin_rise_reg[0]};
   wire [3:0] t1_srcs = {presc_tick[`TBT_T1_TAP_C], presc_tick[`TBT_T1_TAP_B],
                         presc_tick[`TBT_T1_TAP_A], pin_rise_reg[2]};
   wire tbt_pkg::tbt_sel_t t0_source_sel = ctrl_reg[`TBT_CTRL_T0_SRC_LSB +: 2];
   wire tbt_pkg::tbt_sel_t t1_source_sel = ctrl_reg[`TBT_CTRL_T1_SRC_LSB +: 2];
   wire t0_soft_clear = wr_stb & sel_ctrl & wbyte[`TBT_CTRL_T0_CLR_BIT];
   wire t1_soft_clear = wr_stb & sel_ctrl & wbyte[`TBT_CTRL_T1_CLR_BIT];

   assign t0_if.tick = t0_srcs[t0_source_sel];
   assign t0_if.run = run_reg[`TBT_RUN_T0_BIT];
   assign t0_if.clr = t0_soft_clear;
   assign t0_if.com = ctrl_reg[`TBT_CTRL_T0_COM_BIT];
   assign t0_if.cmp = t0_cmp_reg;

   assign t1_if.tick = t1_srcs[t1_source_sel];
   assign t1_if.run = run_reg[`TBT_RUN_T1_BIT];
   assign t1_if.clr = t1_soft_clear;
   assign t1_if.com = ctrl_reg[`TBT_CTRL_T1_COM_BIT];
   assign t1_if.cmp = {t1_cmp_hi_reg, t1_cmp_lo_reg};

   // each timer counts selected pulses and flags compare matches
   tbt_timer #(.W(8)) u_t0 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tif(t0_if)
   );

   tbt_timer #(.W(16)) u_t1 (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tif(t1_if)
   );

   assign t0_match_irq = t0_if.match;
   assign t1_match_irq = t1_if.match;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_req_waiting;
      req && avs_waitrequest;
   endsequence

   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_answer_one: assert property (s_req_waiting |=> s_answer)
      else $error("bus answer not given one cycle after request");

   a_enable_gate_first: assert property (!en_first && !flag_first_reg && !(wr_stb && sel_mode)
                                         |=> !flag_first_reg)
      else $error("first flag set while disabled");

   a_flag_set_first: assert property (set_first |=> flag_first_reg && prescaler_irq_first)
      else $error("first request not latched");

   a_flag_no_soft_set: assert property (!flag_second_reg && !set_second && wr_stb && sel_flags
                                        |=> !flag_second_reg)
      else $error("software write set a request flag");

   a_unused_read_ones: assert property (rd_take && sel_flags
                                        |=> (avs_readdata[7:0] & `TBT_FLAGS_ONES) == `TBT_FLAGS_ONES)
      else $error("unused flag bits did not read one");

   a_snapshot_low: assert property (rd_take && sel_snap_lo |=> avs_readdata[7:0] == $past(presc_cnt[12:5]))
      else $error("snapshot low byte wrong");

   a_stop_holds_count: assert property (!t0_if.run && !t0_if.clr |=> t0_if.count == $past(t0_if.count))
      else $error("stopped timer 0 changed");

   a_soft_clear_now: assert property (t0_soft_clear
                                      |=> t0_if.count == 8'h00 ##1 ctrl_reg[`TBT_CTRL_T0_CLR_BIT] == 1'h0)
      else $error("soft clear did not zero timer 0");

   a_match_clears: assert property (t0_if.tick && t0_if.run && t0_if.com && !t0_if.clr
                                    && t0_if.count == t0_cmp_reg |=> t0_if.count == 8'h00 && t0_match_irq)
      else $error("clear on match failed");

   a_count_step: assert property (t1_if.tick && t1_if.run && !t1_if.clr && t1_if.count != t1_if.cmp
                                  |=> t1_if.count == $past(t1_if.count) + 16'h0001)
      else $error("timer 1 did not step");

   a_t0_cmp_load: assert property (wr_stb && sel_t0 |=> t0_cmp_reg == $past(wbyte))
      else $error("timer 0 compare not loaded");

   a_t1_hi_read: assert property (rd_take && sel_t1_hi |=> avs_readdata[7:0] == $past(t1_if.count[15:8]))
      else $error("timer 1 high byte read wrong");
endmodule

// >>> pkg/tbt_defs.svh
// register offsets, field positions, reset values and tap stages of the time base and timers
`ifndef TBT_DEFS_SVH
`define TBT_DEFS_SVH

// ----------------------------------------------------------------
// register word addresses (Avalon word address = offset)
// ----------------------------------------------------------------
`define TBT_OFS_MODE 8'h23
`define TBT_OFS_SNAP_LO 8'h24
`define TBT_OFS_SNAP_HI 8'h25
`define TBT_OFS_FLAGS 8'h26
`define TBT_OFS_RUN 8'h27
`define TBT_OFS_CTRL 8'h28
`define TBT_OFS_T0 8'h29
`define TBT_OFS_T1_LO 8'h2A
`define TBT_OFS_T1_HI 8'h2B
`define TBT_WIN_TOP 8'h8F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TBT_MODE_W 6
`define TBT_MODE_TAP1_LSB 0
`define TBT_MODE_TAP2_LSB 2
`define TBT_MODE_EN1_BIT 4
`define TBT_MODE_EN2_BIT 5
`define TBT_FLAG_FIRST_BIT 4
`define TBT_FLAG_SECOND_BIT 5
`define TBT_FLAGS_ONES 8'hCF
`define TBT_RUN_W 6
`define TBT_RUN_T0_BIT 0
`define TBT_RUN_T1_BIT 1
`define TBT_CTRL_T0_SRC_LSB 0
`define TBT_CTRL_T0_CLR_BIT 2
`define TBT_CTRL_T0_COM_BIT 3
`define TBT_CTRL_T1_SRC_LSB 4
`define TBT_CTRL_T1_CLR_BIT 6
`define TBT_CTRL_T1_COM_BIT 7
`define TBT_CTRL_KEEP 8'hBB

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TBT_RST_MODE 6'h00
`define TBT_RST_RUN 6'h00
`define TBT_RST_CTRL 8'h00
`define TBT_RST_CMP 8'h00

// ----------------------------------------------------------------
// prescaler geometry and tap stages
// ----------------------------------------------------------------
`define TBT_PRESC_W 21
`define TBT_SNAP_LO_LSB 5
`define TBT_SNAP_HI_LSB 13
`define TBT_TAP1_S0 11
`define TBT_TAP1_S1 13
`define TBT_TAP1_S2 15
`define TBT_TAP1_S3 17
`define TBT_TAP2_S0 12
`define TBT_TAP2_S1 14
`define TBT_TAP2_S2 16
`define TBT_TAP2_S3 18
`define TBT_T0_TAP_A 6
`define TBT_T0_TAP_B 10
`define TBT_T1_TAP_A 2
`define TBT_T1_TAP_B 4
`define TBT_T1_TAP_C 6

`endif

// >>> pkg/tbt_pkg.sv
// shared types of the time base and timer block
package tbt_pkg;
   typedef logic [7:0] tbt_byte_t;
   typedef logic [1:0] tbt_sel_t;
endpackage

// >>> pkg/tbt_tmr_if.sv
// link between the register side and one timer counter
`timescale 1ns/10ps
interface tbt_tmr_if #(parameter int W = 8);
   logic tick;
   logic run;
   logic clr;
   logic com;
   logic [W-1:0] cmp;
   logic [W-1:0] count;
   logic match;
   modport ctl (output tick, output run, output clr, output com, output cmp, input count, input match);
   modport tmr (input tick, input run, input clr, input com, input cmp, output count, output match);
endinterface

// >>> src/tbt_prescaler.sv
// free-running prescaler with per-stage rising-edge ticks
`timescale 1ns/10ps
module tbt_prescaler #(
   parameter int W = 21
) (
   input wire logic mclk,
   input wire logic sys_rst,
   output logic [W-1:0] count,
   output logic [W-1:0] tick
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic [W-1:0] tick_reg;

   assign cnt_next = cnt_reg + {{(W-1){1'h0}}, 1'h1};
   assign count = cnt_reg;
   assign tick = tick_reg;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         tick_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= cnt_next & ~cnt_reg;
      end
   end
endmodule

// >>> src/tbt_timer.sv
// up counter with run gate, soft clear and clear on compare match
`timescale 1ns/10ps
module tbt_timer #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   tbt_tmr_if.tmr tif
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic match_reg;
   logic step;
   logic hit;

   assign step = tif.run & tif.tick;
   assign hit = (count_reg == tif.cmp);
   assign tif.count = count_reg;
   assign tif.match = match_reg;

   always_comb begin
      count_next = count_reg;
      if (tif.clr) begin
         count_next = '0;
      end else if (step) begin
         if (hit && tif.com) begin
            count_next = '0;
         end else begin
            count_next = count_reg + {{(W-1){1'h0}}, 1'h1};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_reg <= '0;
         match_reg <= 1'h0;
      end else begin
         count_reg <= count_next;
         match_reg <= step & hit & ~tif.clr;
      end
   end
endmodule

// >>> testbench/tbt_top_test.sv
// self-checking bench for the prescaler, its request flags and timers 0 and 1
`timescale 1ns/10ps
module tbt_top_test;
   // ----------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------
   typedef struct {logic [7:0] a; logic [7:0] d; logic [3:0] be; logic [7:0] m; logic [7:0] e;} tbt_row_s;
   typedef struct {logic t1; logic [1:0] src; logic [15:0] cmp; int per;} tbt_trow_s;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic control_track_pulse = 1'b0;
   logic t0_external_input = 1'b0;
   logic t1_external_input = 1'b0;
   logic irq1, irq2, m0, m1;
   logic [7:0] q;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int pin_div = 0;
   int n;
   tbt_row_s rows [14] = '{
      '{8'h27, 8'h3F, 4'h1, 8'hFF, 8'h3F}, '{8'h27, 8'h00, 4'h1, 8'hFF, 8'h00},
      '{8'h28, 8'hFF, 4'h1, 8'hFF, 8'hBB}, '{8'h28, 8'h00, 4'h1, 8'hFF, 8'h00},
      '{8'h23, 8'h3F, 4'h1, 8'h3F, 8'h3F}, '{8'h23, 8'h00, 4'h1, 8'h3F, 8'h00},
      '{8'h23, 8'h3F, 4'h0, 8'h3F, 8'h00}, '{8'h26, 8'hFF, 4'h1, 8'hFF, 8'hCF},
      '{8'h26, 8'h00, 4'h1, 8'hFF, 8'hCF}, '{8'h29, 8'h55, 4'h1, 8'hFF, 8'h00},
      '{8'h2A, 8'h12, 4'h1, 8'hFF, 8'h00}, '{8'h2B, 8'h34, 4'h1, 8'hFF, 8'h00},
      '{8'h90, 8'hFF, 4'h1, 8'hFF, 8'h00}, '{8'hFF, 8'hA5, 4'h1, 8'hFF, 8'h00}};
   tbt_trow_s trows [9] = '{
      '{1'b0, 2'b00, 16'h0002, 30}, '{1'b0, 2'b01, 16'h0003, 40},
      '{1'b0, 2'b10, 16'h0002, 384}, '{1'b0, 2'b11, 16'h0001, 4096},
      '{1'b1, 2'b00, 16'h0004, 50}, '{1'b1, 2'b01, 16'h0004, 40},
      '{1'b1, 2'b10, 16'h0003, 128}, '{1'b1, 2'b11, 16'h0001, 256},
      '{1'b1, 2'b01, 16'h0100, 2056}};

   tbt_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .control_track_pulse(control_track_pulse), .t0_external_input(t0_external_input),
      .t1_external_input(t1_external_input), .prescaler_irq_first(irq1), .prescaler_irq_second(irq2),
      .t0_match_irq(m0), .t1_match_irq(m1));

   initial begin
      forever #25 mclk = ~mclk;
   end

   // pins toggle every 5 cycles: one rising edge per 10 cycles
   always @(posedge mclk) begin
      pin_div <= (pin_div == 4) ? 0 : pin_div + 1;
      if (pin_div == 4) begin
         control_track_pulse <= ~control_track_pulse;
         t0_external_input <= ~t0_external_input;
         t1_external_input <= ~t1_external_input;
      end
      cyc <= sys_rst ? 0 : cyc + 1;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      int k;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= w;
      avs_read <= ~w;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      r = avs_readdata[7:0];
      if (k >= 50) chk("waitrequest", 0, 1);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rdv(input logic [7:0] a, output logic [7:0] r);
      bus(1'b0, a, 8'h00, r);
   endtask

   function automatic logic near(input int c, input int k);
      int r;
      r = c % (1 << (k + 1)) - (1 << k);
      return (r >= 0 && r <= 8);
   endfunction

   function automatic logic close(input logic [7:0] v, input int c);
      logic [7:0] d;
      d = v - c[7:0];
      return (d <= 8'h02 || d >= 8'hFE);
   endfunction

   task automatic irq_watch(input logic [7:0] mode, input logic e1, input logic e2, input int k1, input int k2,
                            input int span);
      logic s1, s2;
      s1 = 1'b0;
      s2 = 1'b0;
      wr(8'h23, 8'h00);
      wr(8'h26, 8'hCF);
      wr(8'h23, mode);
      repeat (span) begin
         @(posedge mclk);
         if (irq1 === 1'b1 && !s1) begin
            s1 = 1'b1;
            chk("first tap phase", 1, near(cyc, k1));
         end
         if (irq2 === 1'b1 && !s2) begin
            s2 = 1'b1;
            chk("second tap phase", 1, near(cyc, k2));
         end
      end
      chk("first irq seen", e1, s1);
      chk("second irq seen", e2, s2);
   endtask

   task automatic wait_pulse(input logic t1, output int c);
      c = 0;
      do begin
         @(posedge mclk);
         c++;
      end while ((t1 ? m1 : m0) !== 1'b1 && c < 9000);
      if (c >= 9000) chk("match pulse timeout", 0, 1);
   endtask

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge mclk);
      mismatches++;
      wrap_up;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         avs_byteenable <= rows[i].be;
         wr(rows[i].a, rows[i].d);
         avs_byteenable <= 4'h1;
         rdv(rows[i].a, q);
         chk("register row", rows[i].e, q & rows[i].m);
      end
      irq_watch(8'h31, 1'b1, 1'b1, 13, 12, 16500);
      irq_watch(8'h10, 1'b1, 1'b0, 11, 12, 8300);
      irq_watch(8'h20, 1'b0, 1'b1, 11, 12, 8300);
      rdv(8'h26, q);
      chk("second flag pending", 8'hEF, q);
      wr(8'h26, 8'hFF);
      rdv(8'h26, q);
      chk("ones do not set", 8'hEF, q);
      wr(8'h23, 8'h00);
      repeat (2) @(posedge mclk);
      chk("irq gated off", 0, irq2);
      wr(8'h26, 8'hDF);
      rdv(8'h26, q);
      chk("second flag cleared", 8'hCF, q);
      irq_watch(8'h00, 1'b0, 1'b0, 11, 12, 8300);
      rdv(8'h24, q);
      chk("snapshot low", 1, close(q, cyc >> 5));
      rdv(8'h25, q);
      chk("snapshot high", 1, close(q, cyc >> 13));
      foreach (trows[i]) begin
         wr(8'h27, 8'h00);
         wr(8'h28, 8'h44);
         if (trows[i].t1) begin
            wr(8'h2A, trows[i].cmp[7:0]);
            wr(8'h2B, trows[i].cmp[15:8]);
            wr(8'h28, {2'b10, trows[i].src, 4'h0});
            wr(8'h27, 8'h02);
         end else begin
            wr(8'h29, trows[i].cmp[7:0]);
            wr(8'h28, {4'h0, 2'b10, trows[i].src});
            wr(8'h27, 8'h01);
         end
         wait_pulse(trows[i].t1, n);
         wait_pulse(trows[i].t1, n);
         chk("match period", trows[i].per, n);
      end
      wr(8'h27, 8'h00);
      rdv(8'h2A, q);
      repeat (300) @(posedge mclk);
      rdv(8'h2A, n[7:0]);
      chk("stopped count holds", q, n[7:0]);
      wr(8'h28, 8'h44);
      wr(8'h2A, 8'h02);
      wr(8'h2B, 8'h00);
      wr(8'h28, 8'h10);
      wr(8'h27, 8'h02);
      wait_pulse(1'b1, n);
      repeat (64) @(posedge mclk);
      rdv(8'h2A, q);
      chk("count runs past match", 1, q > 8'h05);
      wr(8'h28, 8'h50);
      rdv(8'h2A, q);
      chk("soft clear", 1, q <= 8'h01);
      rdv(8'h28, q);
      chk("soft clear bit reads 0", 8'h10, q);
      wr(8'h27, 8'h3F);
      wr(8'h23, 8'h3F);
      wr(8'h28, 8'h8B);
      sys_rst <= 1'b1;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      chk("irqs in reset", 4'h0, {irq1, irq2, m0, m1});
      for (int i = 0; i < 9; i++) begin
         rdv(8'h23 + i[7:0], q);
         chk("reset value", (i == 3) ? 8'hCF : 8'h00, q);
      end
      wrap_up;
   end
endmodule
